// ### rtl/ctrl_mem.sv
module ctrl_mem
    import hbp_pkg::*;
(
    // Clock
    input  wire logic              core_clk_i,
    input  wire logic              ce_i,
    // Host port side
    input  wire logic              we_i,
    input  wire logic [CM_AW-1:0]  waddr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic [CM_AW-1:0]  host_raddr_i,
    output logic      [DATA_W-1:0] host_rdata_o,
    // Switching side
    input  wire logic [CM_AW-1:0]  sw_raddr_i,
    output logic      [DATA_W-1:0] sw_rdata_o
);

    // Contents survive reset; software must initialise them
    logic [DATA_W-1:0] mem_ff [CM_DEPTH];
    logic [DATA_W-1:0] host_q_ff;
    logic [DATA_W-1:0] sw_q_ff;

    always_ff @(posedge core_clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem_ff[waddr_i] <= wdata_i;
            end
            host_q_ff <= mem_ff[host_raddr_i];
            sw_q_ff   <= mem_ff[sw_raddr_i];
        end
    end

    assign host_rdata_o = host_q_ff;
    assign sw_rdata_o   = sw_q_ff;

endmodule // ctrl_mem

// ### rtl/hbp_pkg.sv
package hbp_pkg;

    // Bus style, one-hot
    typedef enum logic [2:0] {
        STYLE_STROBE = 3'b001,
        STYLE_SEP    = 3'b010,
        STYLE_MUX    = 3'b100
    } bus_style_e;

    // Access sequencer, one-hot
    typedef enum logic [2:0] {
        ACC_IDLE  = 3'b001,
        ACC_READ  = 3'b010,
        ACC_WRITE = 3'b100
    } acc_state_e;

    // Strap codes seen on the two low address pins
    localparam logic [1:0] STRAP_STROBE = 2'h3;
    localparam logic [1:0] STRAP_SEP    = 2'h0;

    // Bus widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned SYNC_W = 16;

    // Register offsets, bank select cleared (operational bank)
    localparam logic [3:0] REG_CM_ADDR = 4'h0;
    localparam logic [3:0] REG_CM_DATA = 4'h1;
    localparam logic [3:0] REG_STATUS  = 4'h2;
    // Register offsets, bank select set (initialization bank)
    localparam logic [3:0] REG_SETUP0  = 4'h0;
    localparam int unsigned SETUP_NUM  = 4;
    // Visible in both banks
    localparam logic [3:0] REG_OPMODE  = 4'hf;

    // Field positions and reset values
    localparam int unsigned BANK_BIT_POS  = 0;
    localparam logic [7:0]  OPMODE_RST    = 8'h00;
    localparam logic [7:0]  SETUP_RST     = 8'h00;
    localparam logic [7:0]  CM_ADDR_RST   = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ = 8'h00;

    // Muxed mode: byte address is twice the register index
    localparam int unsigned MUX_IDX_LSB = 1;

    // Control memory geometry
    localparam int unsigned CM_DEPTH = 32;
    localparam int unsigned CM_AW    = 5;

endpackage : hbp_pkg

// ### rtl/host_bus_port.sv
// Summary of operation
// - Interrupt pin is open drain, pulled low while service is requested.
// - High level on the hardware reset pin holds the port in reset.
// - Low two address pins strapped in reset pick the bus style.
// - In multiplexed style address bit 0 pin acts as address latch strobe.
// - Multiplexed style uses even addresses only; data on the low byte lane.
// - Port has 8 data lines, 4 address lines, select, two controls, irq, reset.
// - Non-multiplexed decode uses address lines plus the bank select bit.
// - Bank select 1 maps setup registers; 0 maps operational registers.
// - Operation mode register is reachable in either bank.
// - Host writes pointer B into control memory location A to switch.
// - Address latch is transparent while strobe high, holds on its fall.
// - Strobe style: read/write line high reads, low writes; rising strobe ends.
// - Access only with select low; in separate and muxed styles a low read or write strobe picks direction.
// - Data lines are driven only while returning read data.
module host_bus_port
    import hbp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              core_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              ce_i,
    // Host pins, inputs
    input  wire logic              hw_reset_in_i,
    input  wire logic              cs_n_i,
    input  wire logic              rd_or_data_strobe_n_i,
    input  wire logic              wr_n_or_rw_i,
    input  wire logic [3:1]        addr_lines_i,
    input  wire logic              addr0_or_latch_pin_i,
    // Host data pins
    input  wire logic [DATA_W-1:0] muxed_bus_lines_i,
    output logic      [DATA_W-1:0] muxed_bus_lines_o,
    output logic                   muxed_bus_lines_oe_o,
    // Interrupt pin
    input  wire logic              irq_req_i,
    output logic                   int_n_o,
    output logic                   int_n_oe_o,
    // Switching side
    input  wire logic [CM_AW-1:0]  sw_slot_i,
    output logic      [DATA_W-1:0] sw_ptr_o,
    // Device configuration
    output logic [SETUP_NUM*DATA_W-1:0] init_cfg_o,
    output logic      [2:0]        bus_style_o
);

    // Synchronised pins
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic              hwres_s;
    logic              cs_n_s;
    logic              strb_n_s;
    logic              wr_rw_s;
    logic [3:1]        addr_s;
    logic              a0_s;
    logic [DATA_W-1:0] bus_s;

    assign pins_raw = {hw_reset_in_i, cs_n_i, rd_or_data_strobe_n_i, wr_n_or_rw_i,
                       addr_lines_i, addr0_or_latch_pin_i, muxed_bus_lines_i};

    pin_sync2 #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .ce_i       (ce_i),
        .async_i    (pins_raw),
        .sync_o     (pins_s)
    );

    assign {hwres_s, cs_n_s, strb_n_s, wr_rw_s, addr_s, a0_s, bus_s} = pins_s;

    // Reset state is held by either reset
    logic in_reset;
    assign in_reset = !rstn_i || hwres_s;

    // State
    bus_style_e         style_ff,   nxt_style;
    acc_state_e         acc_ff,     nxt_acc;
    logic [DATA_W-1:0]  latch_ff,   nxt_latch;
    logic [ADDR_W-1:0]  cap_addr_ff, nxt_cap_addr;
    logic [DATA_W-1:0]  cap_data_ff, nxt_cap_data;
    logic [DATA_W-1:0]  opmode_ff,  nxt_opmode;
    logic [DATA_W-1:0]  cm_addr_ff, nxt_cm_addr;
    logic [DATA_W-1:0]  setup_ff   [SETUP_NUM];
    logic [DATA_W-1:0]  nxt_setup  [SETUP_NUM];
    logic [DATA_W-1:0]  rdata_ff,   nxt_rdata;
    logic               doe_ff,     nxt_doe;
    logic               irq_ff,     nxt_irq;

    // Decoded access terms
    logic              selected;
    logic              rd_act;
    logic              wr_act;
    logic [ADDR_W-1:0] eff_addr;
    logic              bank;
    logic              reg_we;
    logic              cm_we;
    logic [DATA_W-1:0] cm_host_q;
    logic [DATA_W-1:0] sw_q;
    logic [DATA_W-1:0] rd_mux;

    assign bank = opmode_ff[BANK_BIT_POS];

    always_comb begin
        selected = !cs_n_s;
        rd_act   = 1'b0;
        wr_act   = 1'b0;
        unique case (style_ff)
            STYLE_STROBE: begin
                rd_act = selected && !strb_n_s && wr_rw_s;
                wr_act = selected && !strb_n_s && !wr_rw_s;
            end
            STYLE_SEP, STYLE_MUX: begin
                rd_act = selected && !strb_n_s;
                wr_act = selected && !wr_rw_s;
            end
            default: begin
                rd_act = 1'b0;
                wr_act = 1'b0;
            end
        endcase
        // Muxed index drops the always-zero byte-lane bit
        if (style_ff == STYLE_MUX) begin
            eff_addr = latch_ff[MUX_IDX_LSB +: ADDR_W];
        end else begin
            eff_addr = {addr_s, a0_s};
        end
    end

    // Strap, latch and access sequencer
    always_comb begin
        nxt_style    = style_ff;
        nxt_latch    = latch_ff;
        nxt_acc      = acc_ff;
        nxt_cap_addr = cap_addr_ff;
        nxt_cap_data = cap_data_ff;
        reg_we       = 1'b0;
        if (in_reset) begin
            // Straps tracked throughout reset, frozen on release
            if ({addr_s[1], a0_s} == STRAP_STROBE) begin
                nxt_style = STYLE_STROBE;
            end else if ({addr_s[1], a0_s} == STRAP_SEP) begin
                nxt_style = STYLE_SEP;
            end else begin
                nxt_style = STYLE_MUX;
            end
            nxt_acc = ACC_IDLE;
        end else begin
            // Pin 0 is the latch strobe in muxed style
            if (style_ff == STYLE_MUX && a0_s) begin
                nxt_latch = bus_s;
            end
            unique case (acc_ff)
                ACC_IDLE: begin
                    if (rd_act) begin
                        nxt_acc = ACC_READ;
                    end else if (wr_act) begin
                        nxt_acc = ACC_WRITE;
                    end
                    nxt_cap_addr = eff_addr;
                    nxt_cap_data = bus_s;
                end
                ACC_READ: begin
                    if (!rd_act) begin
                        nxt_acc = ACC_IDLE;
                    end
                end
                ACC_WRITE: begin
                    // Data taken until strobe release; commit on release
                    if (wr_act) begin
                        nxt_cap_addr = eff_addr;
                        nxt_cap_data = bus_s;
                    end else begin
                        nxt_acc = ACC_IDLE;
                        reg_we  = 1'b1;
                    end
                end
                default: begin
                    nxt_acc = ACC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (ce_i) begin
            style_ff    <= nxt_style;
            latch_ff    <= nxt_latch;
            acc_ff      <= nxt_acc;
            cap_addr_ff <= nxt_cap_addr;
            cap_data_ff <= nxt_cap_data;
        end
    end

    // Register file
    always_comb begin
        nxt_opmode  = opmode_ff;
        nxt_cm_addr = cm_addr_ff;
        cm_we       = 1'b0;
        for (int i = 0; i < SETUP_NUM; i++) begin
            nxt_setup[i] = setup_ff[i];
        end
        if (in_reset) begin
            nxt_opmode  = OPMODE_RST;
            nxt_cm_addr = CM_ADDR_RST;
            for (int i = 0; i < SETUP_NUM; i++) begin
                nxt_setup[i] = SETUP_RST;
            end
        end else if (reg_we) begin
            if (cap_addr_ff == REG_OPMODE) begin
                nxt_opmode = cap_data_ff;
            end else if (bank) begin
                for (int i = 0; i < SETUP_NUM; i++) begin
                    if (cap_addr_ff == REG_SETUP0 + ADDR_W'(i)) begin
                        nxt_setup[i] = cap_data_ff;
                    end
                end
            end else if (cap_addr_ff == REG_CM_ADDR) begin
                nxt_cm_addr = cap_data_ff;
            end else if (cap_addr_ff == REG_CM_DATA) begin
                cm_we = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (ce_i) begin
            opmode_ff  <= nxt_opmode;
            cm_addr_ff <= nxt_cm_addr;
            for (int i = 0; i < SETUP_NUM; i++) begin
                setup_ff[i] <= nxt_setup[i];
            end
        end
    end

    // Pointer at location A; switching side reads it per slot
    ctrl_mem u_cm (
        .core_clk_i   (core_clk_i),
        .ce_i         (ce_i),
        .we_i         (cm_we),
        .waddr_i      (cm_addr_ff[CM_AW-1:0]),
        .wdata_i      (cap_data_ff),
        .host_raddr_i (cm_addr_ff[CM_AW-1:0]),
        .host_rdata_o (cm_host_q),
        .sw_raddr_i   (sw_slot_i),
        .sw_rdata_o   (sw_q)
    );

    // Read path and pin drivers
    always_comb begin
        rd_mux = UNMAPPED_READ;
        if (cap_addr_ff == REG_OPMODE) begin
            rd_mux = opmode_ff;
        end else if (bank) begin
            for (int i = 0; i < SETUP_NUM; i++) begin
                if (cap_addr_ff == REG_SETUP0 + ADDR_W'(i)) begin
                    rd_mux = setup_ff[i];
                end
            end
        end else if (cap_addr_ff == REG_CM_ADDR) begin
            rd_mux = cm_addr_ff;
        end else if (cap_addr_ff == REG_CM_DATA) begin
            rd_mux = cm_host_q;
        end else if (cap_addr_ff == REG_STATUS) begin
            rd_mux = {5'h00, style_ff};
        end
        nxt_rdata = rdata_ff;
        nxt_doe   = 1'b0;
        nxt_irq   = 1'b0;
        if (!in_reset) begin
            if (acc_ff == ACC_READ && rd_act) begin
                nxt_rdata = rd_mux;
                nxt_doe   = 1'b1;
            end
            nxt_irq = irq_req_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (ce_i) begin
            rdata_ff <= nxt_rdata;
            doe_ff   <= nxt_doe;
            irq_ff   <= nxt_irq;
            sw_ptr_o <= sw_q;
        end
    end

    // Open drain: level is always low, only the enable moves
    assign int_n_o              = 1'b0;
    assign int_n_oe_o           = irq_ff;
    assign muxed_bus_lines_o    = rdata_ff;
    assign muxed_bus_lines_oe_o = doe_ff;
    assign bus_style_o          = style_ff;
    always_comb begin
        for (int i = 0; i < SETUP_NUM; i++) begin
            init_cfg_o[i*DATA_W +: DATA_W] = setup_ff[i];
        end
    end

    AST_INT_FOLLOWS: assert property (@(posedge core_clk_i) disable iff (in_reset || !ce_i)
        irq_req_i ##1 ce_i |-> int_n_oe_o && !int_n_o)
        else $error("Interrupt request not driven low on pin");

    AST_HW_RESET: assert property (@(posedge core_clk_i) disable iff (!rstn_i || !ce_i)
        hwres_s |=> opmode_ff == OPMODE_RST && !muxed_bus_lines_oe_o && acc_ff == ACC_IDLE)
        else $error("Hardware reset did not force reset state");

    AST_STRAP_SEP: assert property (@(posedge core_clk_i) disable iff (!ce_i)
        in_reset && addr_s[1] == 1'b0 && a0_s == 1'b0 |=> style_ff == STYLE_SEP)
        else $error("Strap 00 did not select separate-strobe style");

    AST_STYLE_HOLD: assert property (@(posedge core_clk_i) disable iff (in_reset || !ce_i)
        !$past(in_reset) |-> $stable(style_ff))
        else $error("Bus style changed outside reset");

    AST_LATCH_HOLD: assert property (@(posedge core_clk_i) disable iff (in_reset || !ce_i)
        style_ff == STYLE_MUX && !a0_s ##1 !a0_s |-> $stable(latch_ff))
        else $error("Address latch moved while strobe low");

    AST_OPMODE_ANY_BANK: assert property (@(posedge core_clk_i) disable iff (in_reset || !ce_i)
        reg_we && cap_addr_ff == REG_OPMODE |=> opmode_ff == $past(cap_data_ff))
        else $error("Operation mode register write lost");

    AST_CS_IGNORE: assert property (@(posedge core_clk_i) disable iff (in_reset || !ce_i)
        cs_n_s [*2] |-> !reg_we && acc_ff == ACC_IDLE)
        else $error("Access taken while chip select high");

    AST_DRIVE_READ_ONLY: assert property (@(posedge core_clk_i) disable iff (in_reset || !ce_i)
        muxed_bus_lines_oe_o |-> $past(acc_ff == ACC_READ && rd_act && !cs_n_s))
        else $error("Data lines driven outside a read");

    AST_CM_BANK: assert property (@(posedge core_clk_i) disable iff (in_reset || !ce_i)
        cm_we |-> !bank && reg_we && cap_addr_ff == REG_CM_DATA)
        else $error("Control memory written from wrong bank");

endmodule // host_bus_port

// ### rtl/pin_sync2.sv
module pin_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // Clock
    input  wire logic             core_clk_i,
    input  wire logic             ce_i,
    // Data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk_i) begin
        if (ce_i) begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule // pin_sync2

// ### verification/host_cpu_model.sv
module host_cpu_model
    import hbp_pkg::*;
(
    // Clock and device view
    input  wire logic              core_clk_i,
    input  wire logic [2:0]        style_i,
    input  wire logic              dut_oe_i,
    input  wire logic [DATA_W-1:0] bus_i,
    // Host pins
    output logic                   cs_n_o,
    output logic                   rd_n_o,
    output logic                   wr_n_o,
    output logic [3:1]             addr_o,
    output logic                   a0_o,
    output logic [DATA_W-1:0]      bus_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
        {addr_o, a0_o} = 4'h0;
        bus_o = 8'h5a;
    end

    // Straps stay put through reset, no latch pulses meanwhile
    task automatic strap(input logic [1:0] s);
        {addr_o[1], a0_o} = s;
    endtask

    task automatic access(input bit rd, input bit sel, input logic [3:0] off,
                          input logic [7:0] wd, output logic [7:0] rdat);
        int   n;
        logic seen;
        seen = 1'b0;
        n = 0;
        @(negedge core_clk_i);
        if (style_i == STYLE_MUX) begin
            // Wrong address first: latch must follow the bus while open
            bus_o = ~{3'h0, off, 1'b0} & 8'h1e;
            a0_o = 1'b1;
            repeat (2) @(negedge core_clk_i);
            bus_o = {3'h0, off, 1'b0};
            repeat (4) @(negedge core_clk_i);
            a0_o = 1'b0;
            @(negedge core_clk_i);
            bus_o = ~bus_o;
            repeat (3) @(negedge core_clk_i);
        end else begin
            {addr_o, a0_o} = off;
        end
        bus_o = rd ? ~bus_o : wd;
        cs_n_o = ~sel;
        if (style_i == STYLE_STROBE) {rd_n_o, wr_n_o} = {1'b0, rd};
        else {rd_n_o, wr_n_o} = {~rd, rd};
        if (rd && sel) begin
            while (dut_oe_i !== 1'b1 && n < 20) begin
                @(negedge core_clk_i);
                n++;
            end
            repeat (2) @(negedge core_clk_i);
            rdat = (n < 20) ? bus_i : 8'hxx;
        end else begin
            repeat (8) begin
                @(negedge core_clk_i);
                seen = seen | dut_oe_i;
            end
            rdat = {7'h0, seen};
        end
        rd_n_o = 1'b1; // Strobe rise ends the access
        if (style_i != STYLE_STROBE) wr_n_o = 1'b1;
        repeat (3) @(negedge core_clk_i);
        {cs_n_o, wr_n_o} = 2'h3;
        bus_o = ~bus_o;
        repeat (6) @(negedge core_clk_i);
    endtask
endmodule // host_cpu_model

// ### verification/tb.sv
module tb
    import hbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             core_clk_i = 1'b0;
    logic             rstn_i = 1'b0;
    logic             ce = 1'b1;
    logic             hw_rst = 1'b0;
    logic             irq = 1'b0;
    logic             irq_q = 1'b0;
    logic             irq_chk = 1'b0;
    logic [CM_AW-1:0] sw_slot = '0;
    logic             cs_n, rd_n, wr_n, a0, bus_oe, int_n, int_oe;
    logic [3:1]       addr;
    logic [7:0]       cpu_bus, dut_bus, bus_w, sw_ptr;
    logic [31:0]      init_cfg;
    logic [2:0]       style;
    int               num_errors = 0;
    int               compares = 0;
    int               opmode, cm_addr;
    int               sexp = 2;
    int               setup[SETUP_NUM];
    int               cm[int];

    assign bus_w = (bus_oe === 1'b1) ? dut_bus : cpu_bus;

    initial forever #10 core_clk_i = ~core_clk_i;

    host_bus_port i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce),
        .hw_reset_in_i(hw_rst), .cs_n_i(cs_n), .rd_or_data_strobe_n_i(rd_n),
        .wr_n_or_rw_i(wr_n), .addr_lines_i(addr), .addr0_or_latch_pin_i(a0),
        .muxed_bus_lines_i(bus_w), .muxed_bus_lines_o(dut_bus),
        .muxed_bus_lines_oe_o(bus_oe), .irq_req_i(irq), .int_n_o(int_n),
        .int_n_oe_o(int_oe), .sw_slot_i(sw_slot), .sw_ptr_o(sw_ptr),
        .init_cfg_o(init_cfg), .bus_style_o(style));

    host_cpu_model i_cpu (.core_clk_i(core_clk_i), .style_i(3'(sexp)),
        .dut_oe_i(bus_oe), .bus_i(bus_w), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .addr_o(addr), .a0_o(a0), .bus_o(cpu_bus));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    always @(posedge core_clk_i) irq_q <= irq;
    always @(negedge core_clk_i) begin
        irq = 1'($urandom_range(1));
        if (irq_chk) chk({int_oe, int_n}, {irq_q, 1'b0}, "interrupt pin");
    end

    function automatic int exp_rd(input logic [3:0] off);
        if (off == REG_OPMODE) return opmode;
        if (opmode[0]) return (off < SETUP_NUM) ? setup[off] : 0;
        case (off)
            REG_CM_ADDR: return cm_addr;
            REG_CM_DATA: return cm[cm_addr % CM_DEPTH];
            REG_STATUS:  return sexp;
            default:     return 0;
        endcase
    endfunction

    task automatic rd(input logic [3:0] off);
        logic [7:0] x;
        i_cpu.access(1'b1, 1'b1, off, 8'h00, x);
        chk(x, exp_rd(off), "register read");
    endtask

    task automatic wr(input logic [3:0] off, input int d);
        logic [7:0] x;
        i_cpu.access(1'b0, 1'b1, off, 8'(d), x);
        chk(x, 0, "data lines driven in write");
        if (off == REG_OPMODE) opmode = d;
        else if (opmode[0]) begin
            if (off < SETUP_NUM) setup[off] = d;
        end else if (off == REG_CM_ADDR) cm_addr = d;
        else if (off == REG_CM_DATA) cm[cm_addr % CM_DEPTH] = d;
    endtask

    task automatic do_reset(input logic [1:0] s, input bit pin);
        @(negedge core_clk_i);
        irq_chk = 1'b0;
        sexp = (s == 2'h3) ? 1 : (s == 2'h0) ? 2 : 4;
        i_cpu.strap(s);
        if (pin) hw_rst = 1'b1;
        else rstn_i = 1'b0;
        repeat (12) @(negedge core_clk_i);
        chk({bus_oe, int_oe}, 0, "outputs in reset");
        {hw_rst, rstn_i} = 2'b01;
        opmode = 0;
        cm_addr = 0;
        setup = '{default: 0};
        repeat (4) @(negedge core_clk_i);
        irq_chk = 1'b1;
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Whole run is a few thousand cycles; this leaves wide margin
    initial begin
        #1000000;
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        logic [7:0] x;
        int         a;
        int         e;
        void'($urandom(87));
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s), s != 0);
            chk(style, sexp, "bus style");
            chk(init_cfg, 0, "setup after reset");
            rd(REG_OPMODE);
            rd(REG_CM_ADDR);
            wr(REG_OPMODE, 1);
            rd(REG_OPMODE);
            e = 0;
            for (int i = 0; i < SETUP_NUM; i++) begin
                wr(REG_SETUP0 + 4'(i), $urandom_range(255));
                e |= setup[i] << (8 * i);
            end
            chk(init_cfg, e, "setup registers");
            for (int i = 0; i < 6; i++) rd(4'(i));
            i_cpu.access(1'b0, 1'b0, REG_OPMODE, 8'h00, x);
            chk(x, 0, "drive with select high");
            i_cpu.access(1'b1, 1'b0, REG_OPMODE, 8'h00, x);
            chk(x, 0, "read with select high");
            rd(REG_OPMODE);
            wr(REG_OPMODE, 0);
            rd(REG_CM_ADDR);
            rd(REG_STATUS);
            rd(4'he);
            a = $urandom_range(CM_DEPTH - 1);
            wr(REG_CM_ADDR, a);
            wr(REG_CM_DATA, $urandom_range(255));
            rd(REG_CM_DATA);
            sw_slot = 5'(a);
            repeat (3) @(negedge core_clk_i);
            chk(sw_ptr, cm[a], "switch pointer");
            // Enable low must freeze the pointer register despite a new slot
            irq_chk = 1'b0;
            ce = 1'b0;
            sw_slot = 5'(a) ^ 5'h01;
            repeat (4) @(negedge core_clk_i);
            chk(sw_ptr, cm[a], "state frozen by enable");
            ce = 1'b1;
            repeat (2) @(negedge core_clk_i);
            irq_chk = 1'b1;
            chk(style, sexp, "style held");
            $display("Style test %0d finished", s);
        end
        end_of_test();
    end
endmodule // tb
